// file: pkg/threshold_stage_defs.vh
`ifndef THRESHOLD_STAGE_DEFS_VH
`define THRESHOLD_STAGE_DEFS_VH

// Clock and timing
`define CLK_HZ              100000000
`define TICK_MS             1
`define DELTA_WINDOW_MS     20
`define TIME_MAX_MS         32'h001B7740

// Global register byte offsets
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_OP_DELAY        8'h08
`define REG_REL_DELAY       8'h0C
`define REG_REMAIN          8'h10
`define REG_EXPECTED        8'h14
`define REG_CALC_PICKUP     8'h18
`define REG_CALC_RATIO      8'h1C

// Per-magnitude register blocks
`define CH_BASE             8'h40
`define CH_STRIDE_SHIFT     5
`define CH_MODE             3'h0
`define CH_SCALE            3'h1
`define CH_PICKUP           3'h2
`define CH_HYST             3'h3
`define CH_BLOCK_LIMIT      3'h4
`define CH_SCALED           3'h5
`define CH_RATIO            3'h6

// Field layout
`define CTRL_SEL_LSB        0
`define CTRL_SEL_MSB        1

// Reset values
`define RST_SEL             2'h1
`define RST_MODE            3'h0
`define RST_SCALE           32'h00010000
`define RST_PICKUP          32'h00000064
`define RST_HYST            32'h00007530
`define RST_BLOCK_LIMIT     32'h80000000
`define RST_OP_DELAY        32'h00000028
`define RST_REL_DELAY       32'h0000003C

// Fixed-point scales
`define FRAC_BITS           16
`define HYST_DIV            1000000
`define REL_PCT_MUL         1000000

// Comparator modes
`define MODE_OVER           3'h0
`define MODE_OVER_ABS       3'h1
`define MODE_UNDER          3'h2
`define MODE_UNDER_ABS      3'h3
`define MODE_DELTA_REL      3'h4
`define MODE_DELTA_REL_ABS  3'h5
`define MODE_DELTA_VAL      3'h6
`define MODE_DELTA_VAL_ABS  3'h7

// Condition encodings
`define COND_NORMAL         2'h0
`define COND_START          2'h1
`define COND_TRIP           2'h2
`define COND_BLOCKED        2'h3

`endif

// file: design/magnitude_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "threshold_stage_defs.vh"

module magnitude_channel
#(
  parameter W = 32
)
(
  input  wire                 sys_clk,
  input  wire                 reset,
  input  wire                 win_tick,
  input  wire                 enable,
  input  wire [2:0]           mode,
  input  wire signed [W-1:0]  scale,
  input  wire signed [W-1:0]  pickup,
  input  wire signed [W-1:0]  hyst,
  input  wire signed [W-1:0]  block_limit,
  input  wire signed [W-1:0]  meas,
  output reg  signed [W-1:0]  scaled_q,
  output reg  signed [W-1:0]  ratio_q,
  output reg                  pick_q
);

  localparam X = 96;

  reg  signed [W-1:0] ref_q;
  reg  signed [X-1:0] q;
  reg  signed [X-1:0] t;
  reg  signed [X-1:0] t_abs;
  reg  signed [X-1:0] h;
  reg  signed [X-1:0] x;
  reg  signed [X-1:0] p;
  reg  signed [X-1:0] diff;
  reg  signed [X-1:0] rabs;
  reg                 pick_d;
  reg                 under_block;
  wire signed [2*W-1:0] prod;
  wire signed [X-1:0] ratio_full;

  // Scaling by Q16.16 factor, 1.0 passes the value unchanged
  assign prod = meas * scale;
  // Signed division: both arms stay signed so negative ratios keep their sign
  assign ratio_full = (pickup == {W{1'b0}}) ? $signed({X{1'b0}}) : (x <<< `FRAC_BITS) / p;

  always @*
  begin
    x    = {{(X-W){scaled_q[W-1]}}, scaled_q};
    p    = {{(X-W){pickup[W-1]}}, pickup};
    diff = x - {{(X-W){ref_q[W-1]}}, ref_q};
    rabs = ref_q[W-1] ? -{{(X-W){ref_q[W-1]}}, ref_q} : {{(X-W){1'b0}}, ref_q};
    under_block = 1'b0;
    q = x;
    t = p;
    case (mode)
      `MODE_OVER:
      begin
        q = x;
        t = p;
      end
      `MODE_OVER_ABS:
      begin
        q = x[X-1] ? -x : x;
        t = p;
      end
      `MODE_UNDER:
      begin
        q = -x;
        t = -p;
        under_block = (scaled_q < block_limit);
      end
      `MODE_UNDER_ABS:
      begin
        q = x[X-1] ? x : -x;
        t = -p;
        under_block = (scaled_q < block_limit);
      end
      `MODE_DELTA_REL:
      begin
        q = p[X-1] ? -(diff * `REL_PCT_MUL) : diff * `REL_PCT_MUL;
        t = (p[X-1] ? -p : p) * rabs;
      end
      `MODE_DELTA_REL_ABS:
      begin
        q = (diff[X-1] ? -diff : diff) * `REL_PCT_MUL;
        t = (p[X-1] ? -p : p) * rabs;
      end
      `MODE_DELTA_VAL:
      begin
        q = p[X-1] ? -diff : diff;
        t = p[X-1] ? -p : p;
      end
      `MODE_DELTA_VAL_ABS:
      begin
        q = diff[X-1] ? -diff : diff;
        t = p[X-1] ? -p : p;
      end
      default:
      begin
        q = x;
        t = p;
      end
    endcase
    t_abs = t[X-1] ? -t : t;
    // Hysteresis in units of 0.0001 percent of the threshold
    h = (t_abs * {{(X-W){hyst[W-1]}}, hyst}) / `HYST_DIV;
    if (!enable || under_block)
      pick_d = 1'b0;
    else if (pick_q)
      pick_d = (q >= t - h);
    else
      pick_d = (q > t);
  end

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      scaled_q <= {W{1'b0}};
      ratio_q  <= {W{1'b0}};
      ref_q    <= {W{1'b0}};
      pick_q   <= 1'b0;
    end
    else
    begin
      scaled_q <= prod[W+`FRAC_BITS-1:`FRAC_BITS];
      ratio_q  <= ratio_full[W-1:0];
      pick_q   <= pick_d;
      if (win_tick)
        ref_q <= scaled_q;
    end
  end

endmodule
`default_nettype wire

// file: design/programmable_stage.v
`timescale 1ns/1ps
`default_nettype none
`include "threshold_stage_defs.vh"

module programmable_stage
#(
  parameter W             = 32,
  parameter CYCLES_PER_MS = `CLK_HZ / 1000
)
(
  input  wire          sys_clk,
  input  wire          reset,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  input  wire [W-1:0]  meas_in_0,
  input  wire [W-1:0]  meas_in_1,
  input  wire [W-1:0]  meas_in_2,
  input  wire          block_in,
  output reg           start_q,
  output reg           trip_q,
  output reg           blocked_q
);

  reg  [1:0]   sel_q;
  reg  [31:0]  op_delay_q;
  reg  [31:0]  rel_delay_q;
  reg  [31:0]  remain_q;
  reg  [31:0]  rel_cnt_q;
  reg  [31:0]  expected_q;
  reg  [31:0]  calc_pickup_q;
  reg  [31:0]  calc_ratio_q;
  reg  [31:0]  calc_q;
  reg  [1:0]   cond_q;
  reg  [31:0]  ms_cnt_q;
  reg  [4:0]   win_cnt_q;
  reg          ms_tick_q;
  reg          win_tick_q;
  reg  [2:0]   mode_q [0:2];
  reg  [31:0]  scale_q [0:2];
  reg  [31:0]  pickup_q [0:2];
  reg  [31:0]  hyst_q [0:2];
  reg  [31:0]  blim_q [0:2];
  wire [W-1:0] meas [0:2];
  wire [W-1:0] scaled [0:2];
  wire [W-1:0] ratio [0:2];
  wire [2:0]   pick;
  wire         any_pick;
  wire         wr;
  wire         rd;
  wire         in_ch;
  wire [7:0]   ch_off;
  wire [1:0]   ch;
  wire         follow_1;
  wire         follow_2;
  wire [2:0]   reg_idx;
  wire [33:0]  calc_sum;
  wire signed [63:0] calc_ratio_full;
  reg  [31:0]  rd_d;
  integer      i;

  assign meas[0] = meas_in_0;
  assign meas[1] = meas_in_1;
  assign meas[2] = meas_in_2;
  assign wr      = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign in_ch   = (wb_adr_i >= `CH_BASE) && (wb_adr_i < `CH_BASE + 8'h60);
  assign ch_off  = wb_adr_i - `CH_BASE;
  assign ch      = ch_off[`CH_STRIDE_SHIFT+1:`CH_STRIDE_SHIFT];
  assign reg_idx = wb_adr_i[4:2];
  assign any_pick = |pick;

  // Byte-lane merge for writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (be[k])
          merge[8*k +: 8] = nw[8*k +: 8];
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gen_ch
      magnitude_channel #(.W(W)) u_ch
      (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .win_tick    (win_tick_q),
        .enable      (g < ((sel_q == 2'h0) ? 2'h1 : sel_q)),
        .mode        (mode_q[g]),
        .scale       (scale_q[g][W-1:0]),
        .pickup      (pickup_q[g][W-1:0]),
        .hyst        (hyst_q[g][W-1:0]),
        .block_limit (blim_q[g][W-1:0]),
        .meas        (meas[g]),
        .scaled_q    (scaled[g]),
        .ratio_q     (ratio[g]),
        .pick_q      (pick[g])
      );
    end
  endgenerate

  // Combined magnitude: sum of the followed scaled magnitudes
  assign follow_1 = (sel_q >= 2'h2);
  assign follow_2 = (sel_q == 2'h3);
  assign calc_sum = {{2{scaled[0][W-1]}}, scaled[0]}
                  + (follow_1 ? {{2{scaled[1][W-1]}}, scaled[1]} : 34'h000000000)
                  + (follow_2 ? {{2{scaled[2][W-1]}}, scaled[2]} : 34'h000000000);
  assign calc_ratio_full = (calc_pickup_q == 32'h00000000) ? 64'sh0000000000000000 :
                           ($signed({{32{calc_q[31]}}, calc_q}) <<< `FRAC_BITS)
                           / $signed({{32{calc_pickup_q[31]}}, calc_pickup_q});

  // Millisecond and delta-window ticks
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      ms_cnt_q   <= 32'h00000000;
      win_cnt_q  <= 5'h00;
      ms_tick_q  <= 1'b0;
      win_tick_q <= 1'b0;
    end
    else
    begin
      ms_tick_q  <= 1'b0;
      win_tick_q <= 1'b0;
      if (ms_cnt_q == CYCLES_PER_MS - 1)
      begin
        ms_cnt_q  <= 32'h00000000;
        ms_tick_q <= 1'b1;
        if (win_cnt_q == `DELTA_WINDOW_MS - 1)
        begin
          win_cnt_q  <= 5'h00;
          win_tick_q <= 1'b1;
        end
        else
          win_cnt_q <= win_cnt_q + 5'h01;
      end
      else
        ms_cnt_q <= ms_cnt_q + 32'h00000001;
    end
  end

  // Condition state machine
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      cond_q     <= `COND_NORMAL;
      remain_q   <= 32'h00000000;
      rel_cnt_q  <= 32'h00000000;
      expected_q <= 32'h00000000;
    end
    else
    begin
      expected_q <= op_delay_q;
      case (cond_q)
        `COND_NORMAL:
        begin
          rel_cnt_q <= 32'h00000000;
          if (any_pick && block_in)
            cond_q <= `COND_BLOCKED;
          else if (any_pick)
          begin
            cond_q   <= `COND_START;
            remain_q <= op_delay_q;
          end
        end
        `COND_START, `COND_TRIP:
        begin
          if (block_in && any_pick)
          begin
            cond_q   <= `COND_BLOCKED;
            remain_q <= 32'h00000000;
          end
          else if (!any_pick)
          begin
            if (rel_cnt_q >= rel_delay_q)
            begin
              cond_q    <= `COND_NORMAL;
              remain_q  <= 32'h00000000;
              rel_cnt_q <= 32'h00000000;
            end
            else if (ms_tick_q)
              rel_cnt_q <= rel_cnt_q + 32'h00000001;
          end
          else
          begin
            rel_cnt_q <= 32'h00000000;
            if (cond_q == `COND_START)
            begin
              if (remain_q == 32'h00000000)
                cond_q <= `COND_TRIP;
              else if (ms_tick_q)
                remain_q <= remain_q - 32'h00000001;
            end
          end
        end
        `COND_BLOCKED:
        begin
          if (!any_pick)
            cond_q <= `COND_NORMAL;
          else if (!block_in)
          begin
            cond_q   <= `COND_START;
            remain_q <= op_delay_q;
          end
        end
        default:
          cond_q <= `COND_NORMAL;
      endcase
    end
  end

  // Outputs and combined magnitude readouts
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      start_q      <= 1'b0;
      trip_q       <= 1'b0;
      blocked_q    <= 1'b0;
      calc_q       <= 32'h00000000;
      calc_ratio_q <= 32'h00000000;
    end
    else
    begin
      start_q      <= (cond_q == `COND_START) || (cond_q == `COND_TRIP);
      trip_q       <= (cond_q == `COND_TRIP);
      blocked_q    <= (cond_q == `COND_BLOCKED);
      calc_q       <= calc_sum[31:0];
      calc_ratio_q <= calc_ratio_full[31:0];
    end
  end

  // Read mux
  always @*
  begin
    rd_d = 32'h00000000;
    if (in_ch)
    begin
      case (reg_idx)
        `CH_MODE:        rd_d = {29'h00000000, mode_q[ch]};
        `CH_SCALE:       rd_d = scale_q[ch];
        `CH_PICKUP:      rd_d = pickup_q[ch];
        `CH_HYST:        rd_d = hyst_q[ch];
        `CH_BLOCK_LIMIT: rd_d = blim_q[ch];
        `CH_SCALED:      rd_d = scaled[ch];
        `CH_RATIO:       rd_d = ratio[ch];
        default:         rd_d = 32'h00000000;
      endcase
    end
    else
    begin
      case (wb_adr_i)
        `REG_CTRL:        rd_d = {30'h00000000, sel_q};
        `REG_STATUS:      rd_d = {30'h00000000, cond_q};
        `REG_OP_DELAY:    rd_d = op_delay_q;
        `REG_REL_DELAY:   rd_d = rel_delay_q;
        `REG_REMAIN:      rd_d = remain_q;
        `REG_EXPECTED:    rd_d = expected_q;
        `REG_CALC_PICKUP: rd_d = calc_pickup_q;
        `REG_CALC_RATIO:  rd_d = calc_ratio_q;
        default:          rd_d = 32'h00000000;
      endcase
    end
  end

  // Wishbone slave and settings
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h00000000;
      sel_q         <= `RST_SEL;
      op_delay_q    <= `RST_OP_DELAY;
      rel_delay_q   <= `RST_REL_DELAY;
      calc_pickup_q <= `RST_PICKUP;
      for (i = 0; i < 3; i = i + 1)
      begin
        mode_q[i]   <= `RST_MODE;
        scale_q[i]  <= `RST_SCALE;
        pickup_q[i] <= `RST_PICKUP;
        hyst_q[i]   <= `RST_HYST;
        blim_q[i]   <= `RST_BLOCK_LIMIT;
      end
    end
    else
    begin
      wb_ack_o <= rd;
      if (rd)
        wb_dat_o <= rd_d;
      if (wr && in_ch)
      begin
        case (reg_idx)
          `CH_MODE:        mode_q[ch]   <= wb_sel_i[0] ? wb_dat_i[2:0] : mode_q[ch];
          `CH_SCALE:       scale_q[ch]  <= merge(scale_q[ch], wb_dat_i, wb_sel_i);
          `CH_PICKUP:      pickup_q[ch] <= merge(pickup_q[ch], wb_dat_i, wb_sel_i);
          `CH_HYST:        hyst_q[ch]   <= merge(hyst_q[ch], wb_dat_i, wb_sel_i);
          `CH_BLOCK_LIMIT: blim_q[ch]   <= merge(blim_q[ch], wb_dat_i, wb_sel_i);
          default:         ;
        endcase
      end
      else if (wr)
      begin
        case (wb_adr_i)
          `REG_CTRL:        sel_q         <= wb_sel_i[0] ? wb_dat_i[1:0] : sel_q;
          `REG_OP_DELAY:    op_delay_q    <= merge(op_delay_q, wb_dat_i, wb_sel_i);
          `REG_REL_DELAY:   rel_delay_q   <= merge(rel_delay_q, wb_dat_i, wb_sel_i);
          `REG_CALC_PICKUP: calc_pickup_q <= merge(calc_pickup_q, wb_dat_i, wb_sel_i);
          default:          ;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/programmable_stage_sva.sv
`timescale 1ns/1ps
`default_nettype none
module programmable_stage_sva
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic block_in,
  input wire logic start_q,
  input wire logic trip_q,
  input wire logic blocked_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_trip_has_start: assert property (trip_q |-> start_q)
    else $error("trip without start");
  a_blocked_alone: assert property (blocked_q |-> !start_q && !trip_q)
    else $error("blocked together with start or trip");
  a_trip_after_start: assert property ($rose(trip_q) |-> $past(start_q))
    else $error("trip rose without prior start");
  a_clear_no_block: assert property ((!block_in) [*4] |-> !blocked_q)
    else $error("blocked while block input low");
  a_reset_quiet: assert property (@(posedge sys_clk) disable iff (1'b0)
    reset |=> !start_q && !trip_q && !blocked_q && !wb_ack_o)
    else $error("outputs active after reset");

  c_trip: cover property ($rose(trip_q));
  c_blocked: cover property ($rose(blocked_q));
  c_access: cover property (wb_ack_o);
endmodule
bind programmable_stage programmable_stage_sva i_programmable_stage_sva
(
  .sys_clk   (sys_clk),
  .reset     (reset),
  .wb_cyc_i  (wb_cyc_i),
  .wb_stb_i  (wb_stb_i),
  .wb_ack_o  (wb_ack_o),
  .block_in  (block_in),
  .start_q   (start_q),
  .trip_q    (trip_q),
  .blocked_q (blocked_q)
);
`default_nettype wire

// file: tb/test_programmable_stage.sv
`timescale 1ns/1ps
`default_nettype none
`include "threshold_stage_defs.vh"
module test_programmable_stage;
  logic        sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, block_in;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, meas_in_0, meas_in_1, meas_in_2, q;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, start_q, trip_q, blocked_q;
  int          n_errors, tests_run, t0, i;
  int          cyc_cnt = 0;

  programmable_stage #(.CYCLES_PER_MS(10)) i_programmable_stage
  (
    .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .meas_in_0(meas_in_0), .meas_in_1(meas_in_1), .meas_in_2(meas_in_2),
    .block_in(block_in), .start_q(start_q), .trip_q(trip_q), .blocked_q(blocked_q)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    cyc_cnt <= cyc_cnt + 1;

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  task chk_range(input string s, input int lo, input int hi, input int g);
    tests_run++;
    if (g < lo || g > hi)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    chk("ack", 32'h1, {31'h0, wb_ack_o});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input string s);
    wb(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask

  // Wait for start (0), trip (1) or blocked (2) to reach v
  task wt(input int k, input logic v, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while ((k == 0 ? start_q : (k == 1 ? trip_q : blocked_q)) !== v && n < lim);
    chk_range("wait cycles", 1, lim - 1, n);
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_errors++;
    give_verdict;
  end

  initial
  begin
    reset <= 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, block_in} <= 4'h0;
    wb_adr_i <= 8'h00;
    wb_sel_i <= 4'h0;
    wb_dat_i <= 32'h0;
    meas_in_0 <= 32'h0;
    meas_in_1 <= 32'h000003E8;
    meas_in_2 <= 32'h0;
    n_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    wb(1'b1, 8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0, "unmapped");
    wb(1'b1, `REG_STATUS, 32'h2);
    rd(`REG_STATUS, {30'h0, `COND_NORMAL}, "status ro");
    rd(`REG_CTRL, {30'h0, `RST_SEL}, "ctrl");
    rd(`REG_OP_DELAY, 32'h28, "op delay");
    rd(`REG_REL_DELAY, 32'h3C, "rel delay");
    rd(`REG_EXPECTED, 32'h28, "expected");
    rd(8'h40, 32'h0, "mode");
    rd(8'h44, 32'h00010000, "scale");
    rd(8'h48, 32'h64, "pickup");
    rd(8'h4C, 32'h7530, "hyst");
    rd(8'h50, 32'h80000000, "block limit");
    wb(1'b1, 8'h50, 32'h1);
    for (i = 7; i >= 0; i--)
    begin
      wb(1'b1, 8'h40, i);
      rd(8'h40, i, "mode sel");
    end
    chk("idle modes", 32'h0, {31'h0, start_q});
    wb(1'b1, `REG_OP_DELAY, 32'h3);
    wb(1'b1, `REG_REL_DELAY, 32'h2);
    wb(1'b1, 8'h44, 32'h00020000);
    meas_in_0 <= 32'h64;
    wt(0, 1'b1, 20);
    t0 = cyc_cnt;
    rd(`REG_STATUS, {30'h0, `COND_START}, "status start");
    wb(1'b0, `REG_REMAIN, 32'h0);
    chk_range("remain", 1, 3, q);
    wt(1, 1'b1, 60);
    chk_range("op time", 20, 34, cyc_cnt - t0);
    rd(`REG_STATUS, {30'h0, `COND_TRIP}, "status trip");
    rd(`REG_REMAIN, 32'h0, "remain trip");
    rd(`REG_EXPECTED, 32'h3, "expected set");
    rd(8'h54, 32'hC8, "scaled");
    rd(8'h58, 32'h00020000, "ratio");
    rd(`REG_CALC_RATIO, 32'h00020000, "calc ratio");
    meas_in_0 <= 32'h31;
    repeat (40) @(posedge sys_clk);
    chk("held", 32'h1, {31'h0, start_q});
    meas_in_0 <= 32'h30;
    t0 = cyc_cnt;
    wt(0, 1'b0, 60);
    chk_range("release time", 10, 30, cyc_cnt - t0);
    rd(`REG_STATUS, {30'h0, `COND_NORMAL}, "status normal");
    block_in <= 1'b1;
    meas_in_0 <= 32'h64;
    wt(2, 1'b1, 20);
    chk("start blocked", 32'h0, {31'h0, start_q});
    rd(`REG_STATUS, {30'h0, `COND_BLOCKED}, "status blocked");
    block_in <= 1'b0;
    wt(0, 1'b1, 20);
    meas_in_0 <= 32'h0;
    wt(0, 1'b0, 60);
    wb(1'b1, 8'h40, {29'h0, `MODE_UNDER});
    wb(1'b1, 8'h50, 32'h3C);
    meas_in_0 <= 32'h19;
    repeat (30) @(posedge sys_clk);
    chk("under limited", 32'h0, {31'h0, start_q});
    wb(1'b1, 8'h50, 32'h80000000);
    wt(0, 1'b1, 20);
    wb(1'b1, 8'h40, {29'h0, `MODE_OVER});
    meas_in_0 <= 32'h0;
    wt(0, 1'b0, 60);
    wb(1'b1, `REG_CTRL, 32'h2);
    rd(8'h74, 32'h3E8, "scaled unity");
    wt(0, 1'b1, 20);
    wb(1'b1, `REG_CTRL, 32'h1);
    wt(0, 1'b0, 60);
    wb(1'b1, 8'h40, {29'h0, `MODE_DELTA_VAL});
    repeat (210) @(posedge sys_clk);
    chk("delta quiet", 32'h0, {31'h0, start_q});
    meas_in_0 <= 32'h64;
    wt(0, 1'b1, 20);
    wt(0, 1'b0, 300);
    give_verdict;
  end
endmodule
`default_nettype wire
